// ==== logic/dxtpb_core.sv ====
// Purpose: oscillator trim, automatic bandwidth and phase build-out control
// Assumes: sys_clk is the local_oscillator clock; byte-wide register port
// Notes: reference qualities arrive as raw pins and are synchronised
//
// Functional notes
// [RULE1] loop clock comes from the local_oscillator
// [RULE2] sixteen-bit trim from two byte locations
// [RULE3] one trim step equals 0.0196229 ppm
// [RULE4] trim resets to 9999 hex, zero offset
// [RULE5] full unsigned trim range accepted
// [RULE6] ten bandwidth steps, 0.1 to 70 Hz
// [RULE7] automatic acquisition to locked bandwidth change
// [RULE8] loop filter is low-pass at programmed pole
// [RULE9] loss selects next priority, raises build-out
// [RULE10] interruption, off-frequency or absence means loss
// [RULE11] build-out enters temporary holdover
// [RULE12] holdover measures new reference phase
// [RULE13] measured phase inserted as loop offset
// [RULE14] switch transient stays within 5 ns
// [RULE15] jump, slope and holdover accuracy limits
// [RULE16] mode bit clear uses locked bandwidth only
// [RULE17] three-bit damping code, more choices wider
// [RULE18] build-out default on, may disable/freeze
// [RULE19] offset retained until next build-out
// [RULE20] trim minus default corrects frequency always
module dxtpb_core
  import dxtpb_pkg::*;
#(
  parameter int NREF = 4,
  parameter int MEAS_CYCLES = DXTPB_MEAS_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  output logic [7:0] reg_rdata,
  input wire logic [3:0] lock_bw,
  input wire logic [3:0] acq_bw,
  input wire logic [2:0] damp_sel,
  input wire logic [NREF-1:0] ref_short_int,
  input wire logic [NREF-1:0] ref_off_freq,
  input wire logic [NREF-1:0] ref_absent,
  input wire logic signed [DXTPB_PHASE_W-1:0] ref_phase,
  input wire logic phase_locked,
  output logic [$clog2(NREF)-1:0] selected_ref,
  output logic pbo_event,
  output logic holdover,
  output logic locked_out,
  output logic [3:0] active_bw,
  output logic signed [DXTPB_PHASE_W-1:0] pbo_offset,
  output logic signed [DXTPB_PHASE_W-1:0] equipment_clock_out_freq
);
  localparam int SW = $clog2(NREF);
  localparam int CW = $clog2(MEAS_CYCLES + 1);

  // ==========================================================
  // input synchronisers
  logic [3*NREF:0] sync1_reg;
  logic [3*NREF:0] sync2_reg;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {phase_locked, ref_absent, ref_off_freq, ref_short_int};
      sync2_reg <= sync1_reg;
    end
  end
  logic [NREF-1:0] ref_bad;
  logic lock_s;
  assign ref_bad = sync2_reg[NREF-1:0] | sync2_reg[2*NREF-1:NREF] | sync2_reg[3*NREF-1:2*NREF]; // [RULE10]
  assign lock_s = sync2_reg[3*NREF];

  // ==========================================================
  // registers
  logic [15:0] trim_reg;
  logic [15:0] trim_next;
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic pbo_rearm;

  always_comb begin
    trim_next = trim_reg;
    ctrl_next = ctrl_reg;
    pbo_rearm = 1'b0;
    if (reg_wr) begin
      case (reg_addr)
        DXTPB_ADDR_TRIM_LO: begin
          trim_next[7:0] = reg_wdata; // [RULE2] [RULE5]
        end
        DXTPB_ADDR_TRIM_HI: begin
          trim_next[15:8] = reg_wdata; // [RULE2] [RULE5]
        end
        DXTPB_ADDR_CTRL: begin
          ctrl_next = reg_wdata;
          pbo_rearm = reg_wdata[DXTPB_CTRL_PBO_EN] & ~ctrl_reg[DXTPB_CTRL_PBO_EN];
        end
        default: begin
          ctrl_next = ctrl_reg;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      trim_reg <= DXTPB_TRIM_RESET; // [RULE4]
      ctrl_reg <= DXTPB_CTRL_RESET; // [RULE18]
    end else begin
      trim_reg <= trim_next;
      ctrl_reg <= ctrl_next;
    end
  end

  // ==========================================================
  // reference selection, lowest index is highest priority
  function automatic logic [SW:0] pick_ref(input logic [NREF-1:0] bad);
    pick_ref = {1'b1, {SW{1'b0}}};
    for (int i = NREF - 1; i >= 0; i--) begin
      if (!bad[i]) begin
        pick_ref = {1'b0, SW'(i)};
      end
    end
  endfunction : pick_ref

  // ==========================================================
  // build-out state machine
  dxtpb_state_type state_reg;
  dxtpb_state_type state_next;
  logic [SW-1:0] sel_reg;
  logic [SW-1:0] sel_next;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic signed [DXTPB_PHASE_W-1:0] off_reg;
  logic signed [DXTPB_PHASE_W-1:0] off_next;
  logic evt_reg;
  logic evt_next;
  logic [SW:0] best;
  logic pbo_active;

  assign best = pick_ref(ref_bad);
  assign pbo_active = ctrl_reg[DXTPB_CTRL_PBO_EN] & ~ctrl_reg[DXTPB_CTRL_PBO_FREEZE]; // [RULE18]

  always_comb begin
    state_next = state_reg;
    sel_next = sel_reg;
    cnt_next = cnt_reg;
    off_next = off_reg;
    evt_next = 1'b0;
    case (state_reg)
      DXTPB_ACQUIRE, DXTPB_LOCKED: begin
        state_next = lock_s ? DXTPB_LOCKED : DXTPB_ACQUIRE;
        if ((ref_bad[sel_reg] && !best[SW]) || (pbo_rearm && state_reg == DXTPB_LOCKED)) begin
          sel_next = best[SW-1:0]; // [RULE9]
          if (pbo_active || pbo_rearm) begin
            evt_next = 1'b1; // [RULE9]
            cnt_next = '0;
            state_next = DXTPB_HOLD; // [RULE11]
          end else begin
            state_next = DXTPB_ACQUIRE;
          end
        end else if (ref_bad[sel_reg]) begin
          state_next = DXTPB_HOLD;
        end
      end
      DXTPB_HOLD: begin
        if (!ref_bad[sel_reg]) begin
          cnt_next = '0;
          state_next = DXTPB_MEASURE;
        end else if (!best[SW]) begin
          sel_next = best[SW-1:0];
        end
      end
      DXTPB_MEASURE: begin
        cnt_next = CW'(cnt_reg + 1'b1); // [RULE12]
        if (cnt_reg == CW'(MEAS_CYCLES - 1)) begin
          if (pbo_active || pbo_rearm) begin
            off_next = ref_phase; // [RULE13] [RULE14] [RULE15]
          end
          state_next = DXTPB_ACQUIRE;
        end
      end
      default: begin
        state_next = DXTPB_ACQUIRE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg <= DXTPB_ACQUIRE;
      sel_reg <= '0;
      cnt_reg <= '0;
      off_reg <= '0;
      evt_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      sel_reg <= sel_next;
      cnt_reg <= cnt_next;
      off_reg <= off_next; // [RULE19]
      evt_reg <= evt_next;
    end
  end

  // ==========================================================
  // bandwidth selection and loop
  logic [3:0] bw_raw;
  logic [3:0] bw_use;
  logic signed [DXTPB_PHASE_W-1:0] err;
  logic signed [DXTPB_PHASE_W-1:0] loop_freq;
  logic signed [DXTPB_PHASE_W-1:0] trim_corr;
  logic signed [DXTPB_PHASE_W-1:0] freq_reg;
  logic signed [DXTPB_PHASE_W-1:0] freq_next;
  logic hold_loop;

  always_comb begin
    bw_raw = lock_bw;
    if (ctrl_reg[DXTPB_CTRL_AUTO_BW] && state_reg != DXTPB_LOCKED) begin
      bw_raw = acq_bw; // [RULE7] [RULE16]
    end
    bw_use = (bw_raw >= DXTPB_BW_STEPS) ? 4'(DXTPB_BW_STEPS - 1'b1) : bw_raw; // [RULE6]
  end

  assign hold_loop = (state_reg == DXTPB_HOLD) || (state_reg == DXTPB_MEASURE); // [RULE11]
  assign err = DXTPB_PHASE_W'(ref_phase - off_reg); // [RULE13] [RULE19]
  // one trim lsb is one frequency-word lsb of 0.0196229 ppm
  assign trim_corr = DXTPB_PHASE_W'($signed({1'b0, trim_reg}) - $signed({1'b0, DXTPB_TRIM_RESET})); // [RULE3] [RULE20]

  dxtpb_loop_filter #(
    .W(DXTPB_PHASE_W)
  ) u_filter (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .hold(hold_loop),
    .bw_sel(bw_use),
    .damp_sel(damp_sel),
    .phase_err(err),
    .freq_word(loop_freq)
  );

  always_comb begin
    freq_next = DXTPB_PHASE_W'(loop_freq + trim_corr); // [RULE20]
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      freq_reg <= '0;
    end else begin
      freq_reg <= freq_next;
    end
  end

  // ==========================================================
  // read back
  always_comb begin
    case (reg_addr)
      DXTPB_ADDR_TRIM_LO: reg_rdata = trim_reg[7:0];
      DXTPB_ADDR_TRIM_HI: reg_rdata = trim_reg[15:8];
      DXTPB_ADDR_CTRL: reg_rdata = ctrl_reg;
      default: reg_rdata = {4'h0, hold_loop, state_reg == DXTPB_LOCKED, 2'(sel_reg)};
    endcase
  end

  assign selected_ref = sel_reg;
  assign pbo_event = evt_reg;
  assign holdover = hold_loop;
  assign locked_out = (state_reg == DXTPB_LOCKED);
  assign active_bw = bw_use;
  assign pbo_offset = off_reg;
  assign equipment_clock_out_freq = freq_reg;
endmodule : dxtpb_core

// ==== shared/dxtpb_pkg.sv ====
// Purpose: shared constants and types for the oscillator trim and build-out block
// Assumes: one 10 MHz system clock, synchronous active-low reset
// Notes: trim unit is 0.0196229 ppm per step
package dxtpb_pkg;
  // ==========================================================
  // register addresses and trim reset
  localparam logic [1:0] DXTPB_ADDR_TRIM_LO = 2'h0;
  localparam logic [1:0] DXTPB_ADDR_TRIM_HI = 2'h1;
  localparam logic [1:0] DXTPB_ADDR_CTRL = 2'h2;
  localparam logic [1:0] DXTPB_ADDR_STATUS = 2'h3;
  localparam logic [15:0] DXTPB_TRIM_RESET = 16'h9999;
  // ==========================================================
  // control byte fields
  localparam int DXTPB_CTRL_AUTO_BW = 7;
  localparam int DXTPB_CTRL_PBO_EN = 6;
  localparam int DXTPB_CTRL_PBO_FREEZE = 5;
  localparam logic [7:0] DXTPB_CTRL_RESET = 8'h40;
  // ==========================================================
  // bandwidth and damping
  localparam logic [3:0] DXTPB_BW_STEPS = 4'h a;
  localparam logic [3:0] DXTPB_LOCK_BW_RESET = 4'h4;
  localparam logic [3:0] DXTPB_ACQ_BW_RESET = 4'h9;
  localparam logic [2:0] DXTPB_DAMP_RESET = 3'h3;
  // ==========================================================
  // timing
  localparam int DXTPB_CLK_HZ = 10_000_000;
  localparam int DXTPB_MEAS_US = 100;
  localparam int DXTPB_MEAS_CYCLES = (DXTPB_MEAS_US * (DXTPB_CLK_HZ / 1_000_000));
  localparam int DXTPB_PHASE_W = 24;
  typedef enum logic [1:0] {
    DXTPB_ACQUIRE,
    DXTPB_LOCKED,
    DXTPB_HOLD,
    DXTPB_MEASURE
  } dxtpb_state_type;
endpackage : dxtpb_pkg

// ==== logic/dxtpb_loop_filter.sv ====
// Purpose: low-pass loop filter with shift-selected pole and damping
// Assumes: phase error is signed, the same clock as the main block
// Notes: frozen output when hold is high
module dxtpb_loop_filter
  import dxtpb_pkg::*;
#(
  parameter int W = 24
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic hold,
  input wire logic [3:0] bw_sel,
  input wire logic [2:0] damp_sel,
  input wire logic signed [W-1:0] phase_err,
  output logic signed [W-1:0] freq_word
);
  logic signed [W-1:0] integ_reg;
  logic signed [W-1:0] integ_next;
  logic signed [W-1:0] out_reg;
  logic signed [W-1:0] out_next;

  // damping step grows only for the wider bandwidth codes
  function automatic logic [3:0] damp_shift(input logic [3:0] bw, input logic [2:0] d);
    logic [2:0] dmax;
    dmax = (bw >= 4'h9) ? 3'h5 : (bw >= 4'h8) ? 3'h4 : (bw >= 4'h7) ? 3'h3 : (bw >= 4'h6) ? 3'h2 : 3'h1;
    if (d == 3'h0 || d > 3'h5) begin
      d = 3'h3;
    end
    if (d > dmax) begin
      d = dmax;
    end
    damp_shift = 4'(4'h6 - {1'b0, d});
  endfunction : damp_shift

  always_comb begin
    integ_next = integ_reg;
    out_next = out_reg;
    if (!hold) begin
      integ_next = integ_reg + (phase_err >>> (5'h10 - {1'b0, bw_sel})); // [RULE8]
      out_next = integ_reg + (phase_err >>> damp_shift(bw_sel, damp_sel)); // [RULE17]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      integ_reg <= '0;
      out_reg <= '0;
    end else begin
      integ_reg <= integ_next;
      out_reg <= out_next;
    end
  end

  assign freq_word = out_reg;
endmodule : dxtpb_loop_filter

// ==== verif/dxtpb_core_props.sv ====
// Purpose: port checker for dxtpb_core
// Assumes: one clock, sync active-low reset
// Notes: ctrl byte is mirrored from writes
module dxtpb_core_props
  import dxtpb_pkg::*;
#(
  parameter int NREF = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [7:0] reg_rdata,
  input wire logic [3:0] lock_bw,
  input wire logic [3:0] acq_bw,
  input wire logic [NREF-1:0] ref_short_int,
  input wire logic [NREF-1:0] ref_off_freq,
  input wire logic [NREF-1:0] ref_absent,
  input wire logic [$clog2(NREF)-1:0] selected_ref,
  input wire logic pbo_event,
  input wire logic holdover,
  input wire logic locked_out,
  input wire logic [3:0] active_bw,
  input wire logic signed [DXTPB_PHASE_W-1:0] pbo_offset,
  input wire logic signed [DXTPB_PHASE_W-1:0] equipment_clock_out_freq
);
  logic [7:0] ctrl_reg, ctrl_next;
  logic [NREF-1:0] bad;
  logic any_good;
  logic [3:0] acq_c, lock_c;
  always_comb begin
    ctrl_next = ctrl_reg;
    if (reg_wr && reg_addr == DXTPB_ADDR_CTRL) ctrl_next = reg_wdata;
    if (!rst_n) ctrl_next = DXTPB_CTRL_RESET;
  end
  always_ff @(posedge sys_clk) ctrl_reg <= ctrl_next;
  assign bad = ref_short_int | ref_off_freq | ref_absent;
  assign any_good = ~&(bad | (NREF'(1) << selected_ref));
  assign acq_c = (acq_bw > 4'h9) ? 4'h9 : acq_bw;
  assign lock_c = (lock_bw > 4'h9) ? 4'h9 : lock_bw;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence hi_write;
    reg_wr && reg_addr == DXTPB_ADDR_TRIM_HI ##1 reg_addr == DXTPB_ADDR_TRIM_HI;
  endsequence
  a_event_pulse: assert property (pbo_event |=> !pbo_event) else $error("event wider than one cycle");
  a_event_hold: assert property (pbo_event |-> holdover) else $error("event without holdover");
  a_offset_kept: assert property ($changed(pbo_offset) |-> $past(holdover)) else $error("offset moved");
  a_hold_freq: assert property (holdover && $past(holdover, 2) && !$past(reg_wr) && !$past(reg_wr, 2)
    |-> $stable(equipment_clock_out_freq)) else $error("freq moved in holdover");
  a_trim_read: assert property (hi_write |-> reg_rdata == $past(reg_wdata)) else $error("trim readback");
  a_status_map: assert property (reg_addr == DXTPB_ADDR_STATUS
    |-> reg_rdata[3:0] == {holdover, locked_out, selected_ref}) else $error("status bits");
  a_bw_select: assert property (!holdover
    |-> active_bw == ((ctrl_reg[7] && !locked_out) ? acq_c : lock_c)) else $error("bandwidth choice");
  a_event_gated: assert property (pbo_event |-> ctrl_reg[6] && !ctrl_reg[5]) else $error("event gated");
  a_loss_switch: assert property ($rose(bad[selected_ref]) && any_good && !holdover
    |-> ##[1:4] $changed(selected_ref)) else $error("no switch on loss");
endmodule : dxtpb_core_props

// ==== verif/dxtpb_ref_src.sv ====
// Purpose: reference source model
// Assumes: faults are async levels
// Notes: phase of ref n is n*256
module dxtpb_ref_src
  import dxtpb_pkg::*;
#(
  parameter int NREF = 4
) (
  input wire logic [NREF-1:0] fault,
  input wire logic [1:0] kind,
  input wire logic lock_req,
  input wire logic [$clog2(NREF)-1:0] sel,
  output logic [NREF-1:0] short_int,
  output logic [NREF-1:0] off_freq,
  output logic [NREF-1:0] absent,
  output logic signed [DXTPB_PHASE_W-1:0] phase,
  output logic locked
);
  assign short_int = (kind == 2'h0) ? fault : '0;
  assign off_freq = (kind == 2'h1) ? fault : '0;
  assign absent = (kind == 2'h2) ? fault : '0;
  assign phase = DXTPB_PHASE_W'(sel) << 8;
  assign locked = lock_req;
endmodule : dxtpb_ref_src

// ==== verif/dxtpb_core_tb.sv ====
// Purpose: self-checking bench for dxtpb_core
// Assumes: 10 MHz clock, short measure window
// Notes: reset reads first, then trim rows, then hand tests
module dxtpb_core_tb
  import dxtpb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, rst_n, reg_wr, pbo_event, holdover, locked_out, lock_req, plock;
  logic [1:0] reg_addr, sel, kind;
  logic [7:0] reg_wdata, reg_rdata;
  logic [3:0] lock_bw, acq_bw, active_bw, fault, s_i, o_f, a_b;
  logic [2:0] damp_sel;
  logic signed [23:0] ph, pbo_offset, freq;
  logic [39:0] rows [4] = '{{16'h9999, 24'h00_0000}, {16'h0000, 24'hFF_6667},
                            {16'hFFFF, 24'h00_6666}, {16'h989A, 24'hFF_FF01}};
  int n_errors = 0;
  int checks_done = 0;
  // counts event pulses, so a pulse that rises inside a write task is not missed
  int n_evt = 0;
  int e0 = 0;
  always @(posedge sys_clk) if (pbo_event === 1'b1) n_evt++;
  dxtpb_ref_src m_src (.fault(fault), .kind(kind), .lock_req(lock_req), .sel(sel), .short_int(s_i),
    .off_freq(o_f), .absent(a_b), .phase(ph), .locked(plock));
  dxtpb_core #(.MEAS_CYCLES(4)) uut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata), .lock_bw(lock_bw), .acq_bw(acq_bw),
    .damp_sel(damp_sel), .ref_short_int(s_i), .ref_off_freq(o_f), .ref_absent(a_b), .ref_phase(ph),
    .phase_locked(plock), .selected_ref(sel), .pbo_event(pbo_event), .holdover(holdover),
    .locked_out(locked_out), .active_bw(active_bw), .pbo_offset(pbo_offset),
    .equipment_clock_out_freq(freq));
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #5 reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge sys_clk);
    #5 reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    reg_addr = a;
    #1 chk(24'(reg_rdata), 24'(e));
  endtask : rd
  // wait for a level on event, locked or hold, bounded
  task automatic wait_for(input int w, input logic v);
    for (int i = 0; i < 60; i++) begin
      @(posedge sys_clk);
      #1;
      if ((w == 0 ? pbo_event : w == 1 ? locked_out : holdover) === v) break;
    end
  endtask : wait_for
  task automatic finish_test();
    if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    #2_000_000;
    n_errors++;
    finish_test();
  end
  initial begin
    {rst_n, reg_wr, lock_req, reg_addr, kind, reg_wdata, fault} = '0;
    lock_bw = 4'h4;
    acq_bw = 4'hC;
    damp_sel = DXTPB_DAMP_RESET;
    repeat (20) @(posedge sys_clk);
    #5 rst_n = 1'b1;
    rd(0, 8'h99);
    rd(1, 8'h99);
    rd(2, 8'h40);
    rd(3, 8'h00);
    foreach (rows[r]) begin
      wr(0, rows[r][31:24]);
      wr(1, rows[r][39:32]);
      repeat (3) @(posedge sys_clk);
      #1 chk(freq, rows[r][23:0]);
      rd(0, rows[r][31:24]);
      rd(1, rows[r][39:32]);
    end
    chk(24'(active_bw), 24'h4);
    wr(2, 8'hC0);
    #1 chk(24'(active_bw), 24'h9);
    lock_req = 1'b1;
    for (int k = 0; k < 3; k++) begin
      wait_for(1, 1'b1);
      chk(24'(active_bw), 24'h4);
      kind = 2'(k);
      fault[k] = 1'b1;
      wait_for(0, 1'b1);
      chk(24'(sel), 24'(k + 1));
      chk(24'(holdover), 24'h1);
      wait_for(2, 1'b0);
      chk(pbo_offset, 24'((k + 1) << 8));
    end
    wait_for(1, 1'b1);
    e0 = n_evt;
    wr(2, 8'h80);
    wr(2, 8'hC0);
    repeat (2) @(posedge sys_clk);
    #1 chk(24'(n_evt - e0), 24'h1);
    wait_for(2, 1'b0);
    wr(2, 8'hE0);
    fault = 4'he;
    repeat (8) begin
      @(posedge sys_clk);
      #1 chk(24'(pbo_event), 24'h0);
    end
    chk(24'(sel), 24'h0);
    chk(pbo_offset, 24'h00_0300);
    finish_test();
  end
endmodule : dxtpb_core_tb

bind dxtpb_core dxtpb_core_props #(.NREF(NREF)) u_props (.sys_clk(sys_clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata), .lock_bw(lock_bw),
  .acq_bw(acq_bw), .ref_short_int(ref_short_int), .ref_off_freq(ref_off_freq), .ref_absent(ref_absent),
  .selected_ref(selected_ref), .pbo_event(pbo_event), .holdover(holdover), .locked_out(locked_out),
  .active_bw(active_bw), .pbo_offset(pbo_offset), .equipment_clock_out_freq(equipment_clock_out_freq));
